/* File: mmp_map.svh */
// register offsets, field positions, pin positions and address limits for the memory mode block
`ifndef MMP_MAP_SVH
`define MMP_MAP_SVH
`define MMP_OFF_PA_DATA   12'h000
`define MMP_OFF_PA_DIR    12'h004
`define MMP_OFF_PB_DATA   12'h008
`define MMP_OFF_PB_DIR    12'h00C
`define MMP_OFF_PB_ALT    12'h010
`define MMP_OFF_PSW       12'h014
`define MMP_OFF_IRQ_CFG   12'h018
`define MMP_OFF_STATUS    12'h01C
`define MMP_PSW_EA        0
`define MMP_PSW_WS_LO     1
`define MMP_PSW_WS_HI     2
`define MMP_PSW_IDLE      3
`define MMP_PSW_HALT      4
`define MMP_ROM_LO        16'hC000
`define MMP_RAM_HI        16'h02FF
`define MMP_PB_ALE        10
`define MMP_PB_WR         11
`define MMP_PB_HBE        12
`define MMP_PB_RD         15
`define MMP_ZERO16        16'h0000
`define MMP_ZERO32        32'h0000_0000
`define MMP_ONE2          2'h1
`define MMP_ONE3          3'h1
`define MMP_WORD_ADDR_MSB 11
`endif

/* File: mmp_pkg.sv */
// types shared by the memory mode block
package mmp_pkg;
  typedef enum logic [2:0] {
    MMP_IDLE, MMP_ALE, MMP_STROBE, MMP_WAIT, MMP_DONE
  } mmp_bus_state_t;
  typedef enum logic [1:0] {
    MMP_EI_RISE, MMP_EI_FALL, MMP_EI_HIGH, MMP_EI_LOW
  } mmp_ei_mode_t;
  typedef struct packed {
    logic [15:0]    pa_data;
    logic [15:0]    pa_dir;
    logic [15:0]    pb_data;
    logic [15:0]    pb_dir;
    logic [15:0]    pb_alt;
    logic [4:0]     processor_status_word;
    logic [1:0]     ei_mode;
    logic           ei_capture;
    logic           gnd_is_irq;
    logic           bus8;
    logic           strap_taken;
    logic           fault;
    logic           ei_prev;
    logic           ei_irq;
    logic           gnd_irq;
    logic [15:0]    capture;
    mmp_bus_state_t bstate;
    logic [1:0]     ws_cnt;
    logic           ext_write;
    logic [15:0]    ext_addr;
    logic [15:0]    ext_wdata;
    logic [15:0]    mem_rdata;
    logic           mem_done;
    logic           int_sel;
    logic [31:0]    prdata;
  } mmp_state_t;
endpackage

/* File: mmp_top.sv */
// memory mode decode, external bus sequencer, ports A/B and two interrupt pins
// Behaviour
// - clear direction bit makes the pin an input with its driver released
// - input pins: write data register, read pin; outputs: drive pins, read register
// - set alternate bit moves a Port B pin to its secondary function
// - strap low: fetches in C000-FFFF come from internal ROM
// - strap high: the ROM range goes to external memory
// - extended bit 0 limits addresses to ROM and RAM, detection active
// - extended bit 1 allows all 64k, detection off
// - illegal address with detection active asserts the low watchdog fault pin
// - expanded, strap low: ROM on-chip, 0300-BFFF external
// - strap high, bit 0: ROM window is 16k external, detection active
// - strap high, bit 1: 0300-FFFF external, full 64k, no detection
// - RAM and registers 0000-02FF reachable in every mode
// - external mode: Port A is address/data, four Port B pins are strobes
// - read and write strobes only for off-chip addresses
// - high byte enable sampled at reset: high means 8-bit, else 16-bit
// - two status word bits choose one of four wait-state settings
// - a not-ready input stretches the current bus cycle
// - halt stops the bus sequencer, idle keeps the timer; interrupt sensing and register access go on; state is kept
// - dedicated irq pin: edge or level sense, or a fourth input capture
// - shared ground pin is low-active irq ORed with uart irq, or ground
// - reset restarts the block and releases all port drivers, except the Port B strobe pins while the strap is high
`timescale 1ns/1ps
`include "mmp_map.svh"
module mmp_top
  import mmp_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // core access request
  input  wire logic        cpu_req,
  input  wire logic        cpu_write,
  input  wire logic        cpu_fetch,
  input  wire logic        cpu_high,
  input  wire logic [15:0] cpu_addr,
  input  wire logic [15:0] cpu_wdata,
  output logic             cpu_ack,
  output logic             cpu_internal,
  output logic [15:0]      cpu_rdata,
  output logic             cpu_stall,
  // straps and ready
  input  wire logic        external_rom_strap,
  input  wire logic        ext_ready,
  input  wire logic        free_running_timer_tick,
  input  wire logic [15:0] free_running_timer,
  // port a
  input  wire logic [15:0] pa_in,
  output logic [15:0]      pa_out,
  output logic [15:0]      pa_oe_n,
  // port b
  input  wire logic [15:0] pb_in,
  input  wire logic [15:0] pb_alt_out,
  output logic [15:0]      pb_out,
  output logic [15:0]      pb_oe_n,
  // interrupt pins
  input  wire logic        dedicated_ext_irq_pin,
  input  wire logic        shared_ground_irq_pin,
  input  wire logic        uart_irq,
  output logic             ext_irq,
  output logic             shared_irq,
  output logic             capture_valid,
  output logic [15:0]      capture_value,
  // status
  output logic             watchdog_fault_out,
  output logic             watchdog_fault_oe_n,
  output logic             bus_8bit,
  output logic             halted,
  output logic             idle_mode
);
  import mmp_pkg::*;

  mmp_state_t s_reg;
  mmp_state_t s_next;

  // pin view: inputs read the pin, outputs read the register
  function automatic logic [15:0] port_view(input logic [15:0] dat, input logic [15:0] dir,
                                            input logic [15:0] pin);
    port_view = (dat & dir) | (pin & ~dir);
  endfunction

  function automatic logic in_ram(input logic [15:0] a);
    in_ram = (a <= `MMP_RAM_HI);
  endfunction

  function automatic logic in_rom(input logic [15:0] a);
    in_rom = (a >= `MMP_ROM_LO);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // mode decode
  logic ea;
  logic ext_mode;
  logic addr_ext;
  logic addr_int;
  logic illegal;
  logic [11:0] word_off;
  logic apb_access;

  always_comb begin
    ea = s_reg.processor_status_word[`MMP_PSW_EA];
    ext_mode = external_rom_strap | ea;
    // strap picks internal or external ROM; ea opens the gap between RAM and ROM
    addr_int = in_ram(cpu_addr) | (in_rom(cpu_addr) & ~external_rom_strap);
    addr_ext = ~addr_int & (in_rom(cpu_addr) | ea);
    illegal = ~ea & ~in_ram(cpu_addr) & ~in_rom(cpu_addr);
    word_off = {paddr[`MMP_WORD_ADDR_MSB:2], 2'h0};
    apb_access = psel & penable;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_next = s_reg;
    s_next.mem_done = 1'b0;
    // catch the width strap once, on the first edge after reset release
    if (!s_reg.strap_taken) begin
      s_next.bus8 = pb_in[`MMP_PB_HBE];
      s_next.strap_taken = 1'b1;
    end
    // halt freezes the bus sequencer until a status word write or reset; idle keeps the timer tick as its wake source
    if (s_reg.processor_status_word[`MMP_PSW_HALT]) begin
      s_next.processor_status_word[`MMP_PSW_HALT] = 1'b1;
    end else if (s_reg.processor_status_word[`MMP_PSW_IDLE]) begin
      if (free_running_timer_tick) begin
        s_next.processor_status_word[`MMP_PSW_IDLE] = 1'b0;
      end
    end else begin
      case (s_reg.bstate)
        MMP_IDLE: begin
          if (cpu_req) begin
            s_next.ext_addr = cpu_addr;
            s_next.ext_wdata = cpu_wdata;
            s_next.ext_write = cpu_write;
            s_next.int_sel = cpu_high;
            if (illegal) begin
              s_next.fault = 1'b1;
              s_next.mem_done = 1'b1;
            end else if (addr_ext) begin
              s_next.bstate = MMP_ALE;
            end else begin
              s_next.mem_done = 1'b1;
            end
          end
        end
        MMP_ALE: begin
          s_next.bstate = MMP_STROBE;
          s_next.ws_cnt = s_reg.processor_status_word[`MMP_PSW_WS_HI:`MMP_PSW_WS_LO];
        end
        MMP_STROBE: begin
          if (s_reg.ws_cnt != 2'h0) begin
            s_next.ws_cnt = s_reg.ws_cnt - `MMP_ONE2;
          end else if (ext_ready) begin
            s_next.bstate = MMP_DONE;
            s_next.mem_rdata = pa_in;
          end else begin
            s_next.bstate = MMP_WAIT;
          end
        end
        MMP_WAIT: begin
          if (ext_ready) begin
            s_next.bstate = MMP_DONE;
            s_next.mem_rdata = pa_in;
          end
        end
        MMP_DONE: begin
          s_next.bstate = MMP_IDLE;
          s_next.mem_done = 1'b1;
        end
        default: s_next.bstate = MMP_IDLE;
      endcase
    end
    // interrupt pins keep their sensing even in idle
    s_next.ei_prev = dedicated_ext_irq_pin;
    if (s_reg.ei_capture) begin
      s_next.ei_irq = 1'b0;
      if (dedicated_ext_irq_pin & ~s_reg.ei_prev) begin
        s_next.capture = free_running_timer;
      end
    end else begin
      case (mmp_ei_mode_t'(s_reg.ei_mode))
        MMP_EI_RISE: s_next.ei_irq = dedicated_ext_irq_pin & ~s_reg.ei_prev;
        MMP_EI_FALL: s_next.ei_irq = ~dedicated_ext_irq_pin & s_reg.ei_prev;
        MMP_EI_HIGH: s_next.ei_irq = dedicated_ext_irq_pin;
        MMP_EI_LOW:  s_next.ei_irq = ~dedicated_ext_irq_pin;
        default:     s_next.ei_irq = 1'b0;
      endcase
    end
    s_next.gnd_irq = uart_irq | (s_reg.gnd_is_irq & ~shared_ground_irq_pin);
    // register writes
    if (apb_access && pwrite) begin
      case (word_off)
        `MMP_OFF_PA_DATA: s_next.pa_data = pwdata[15:0];
        `MMP_OFF_PA_DIR:  s_next.pa_dir = pwdata[15:0];
        `MMP_OFF_PB_DATA: s_next.pb_data = pwdata[15:0];
        `MMP_OFF_PB_DIR:  s_next.pb_dir = pwdata[15:0];
        `MMP_OFF_PB_ALT:  s_next.pb_alt = pwdata[15:0];
        `MMP_OFF_PSW:     s_next.processor_status_word = pwdata[4:0];
        `MMP_OFF_IRQ_CFG: begin
          s_next.ei_mode = pwdata[1:0];
          s_next.ei_capture = pwdata[2];
          s_next.gnd_is_irq = pwdata[3];
        end
        // writing one clears the fault; a new fault in the same cycle wins
        `MMP_OFF_STATUS:  if (pwdata[0] && !(s_reg.bstate == MMP_IDLE && cpu_req && illegal
                                            && !s_reg.processor_status_word[`MMP_PSW_HALT]
                                            && !s_reg.processor_status_word[`MMP_PSW_IDLE]))
                            s_next.fault = 1'b0;
        default: ;
      endcase
    end
    // register read data, registered for the answer
    s_next.prdata = `MMP_ZERO32;
    case (word_off)
      `MMP_OFF_PA_DATA: s_next.prdata[15:0] = port_view(s_reg.pa_data, s_reg.pa_dir, pa_in);
      `MMP_OFF_PA_DIR:  s_next.prdata[15:0] = s_reg.pa_dir;
      `MMP_OFF_PB_DATA: s_next.prdata[15:0] = port_view(s_reg.pb_data, s_reg.pb_dir, pb_in);
      `MMP_OFF_PB_DIR:  s_next.prdata[15:0] = s_reg.pb_dir;
      `MMP_OFF_PB_ALT:  s_next.prdata[15:0] = s_reg.pb_alt;
      `MMP_OFF_PSW:     s_next.prdata[4:0] = s_reg.processor_status_word;
      `MMP_OFF_IRQ_CFG: s_next.prdata[3:0] = {s_reg.gnd_is_irq, s_reg.ei_capture, s_reg.ei_mode};
      `MMP_OFF_STATUS:  s_next.prdata[5:0] = {s_reg.bstate != MMP_IDLE, ext_mode, s_reg.ei_irq,
                                              s_reg.gnd_irq, s_reg.bus8, s_reg.fault};
      default: ;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.bstate <= MMP_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  logic bus_busy;
  logic strobe_on;
  always_comb begin
    bus_busy = (s_reg.bstate != MMP_IDLE);
    strobe_on = (s_reg.bstate == MMP_STROBE) || (s_reg.bstate == MMP_WAIT);
    // port a: bus owns it in external mode, otherwise direction bits decide
    if (ext_mode) begin
      pa_out = s_reg.ext_addr;
      pa_oe_n = `MMP_ZERO16;
      if (strobe_on || s_reg.bstate == MMP_DONE) begin
        pa_out = s_reg.ext_wdata;
        pa_oe_n = {16{~s_reg.ext_write}};
      end
      if (!bus_busy) begin
        pa_oe_n = ~`MMP_ZERO16;
      end
    end else begin
      pa_out = s_reg.pa_data;
      pa_oe_n = ~s_reg.pa_dir;
    end
    pb_out = (s_reg.pb_data & ~s_reg.pb_alt) | (pb_alt_out & s_reg.pb_alt);
    pb_oe_n = ~s_reg.pb_dir;
    if (ext_mode) begin
      pb_out[`MMP_PB_ALE] = (s_reg.bstate == MMP_ALE);
      pb_out[`MMP_PB_RD] = ~(strobe_on & ~s_reg.ext_write);
      pb_out[`MMP_PB_WR] = ~(strobe_on & s_reg.ext_write);
      pb_out[`MMP_PB_HBE] = ~(bus_busy & (s_reg.int_sel | ~s_reg.bus8));
      pb_oe_n[`MMP_PB_ALE] = 1'b0;
      pb_oe_n[`MMP_PB_RD] = 1'b0;
      pb_oe_n[`MMP_PB_WR] = 1'b0;
      pb_oe_n[`MMP_PB_HBE] = s_reg.bus8; // 8-bit mode leaves the strap pulled high
    end
    pready = 1'b1; // answer in the access cycle, read data from the setup cycle
    prdata = s_reg.prdata;
    pslverr = 1'b0;
    cpu_ack = s_reg.mem_done;
    cpu_rdata = s_reg.mem_rdata;
    cpu_internal = addr_int & ~cpu_fetch ? 1'b1 : addr_int;
    cpu_stall = bus_busy | s_reg.processor_status_word[`MMP_PSW_HALT] | s_reg.processor_status_word[`MMP_PSW_IDLE];
    ext_irq = s_reg.ei_irq;
    shared_irq = s_reg.gnd_irq;
    capture_valid = s_reg.ei_capture;
    capture_value = s_reg.capture;
    // open drain: drive low only while the fault stands
    watchdog_fault_out = 1'b0;
    watchdog_fault_oe_n = ~s_reg.fault;
    bus_8bit = s_reg.bus8;
    halted = s_reg.processor_status_word[`MMP_PSW_HALT];
    idle_mode = s_reg.processor_status_word[`MMP_PSW_IDLE];
  end
endmodule

/* File: mmp_props.sv */
// port assertions for the memory mode block
`timescale 1ns/1ps
module mmp_props (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // core side
  input wire logic        cpu_req,
  input wire logic [15:0] cpu_addr,
  input wire logic        cpu_ack,
  input wire logic        cpu_internal,
  input wire logic        cpu_stall,
  input wire logic        external_rom_strap,
  input wire logic        ext_ready,
  // pins
  input wire logic [15:0] pa_out,
  input wire logic [15:0] pa_oe_n,
  input wire logic [15:0] pb_out,
  input wire logic [15:0] pb_oe_n,
  input wire logic        watchdog_fault_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_ale; cpu_req && $rose(pb_out[10]); endsequence
  sequence s_rd; cpu_req && cpu_stall && !pb_out[15] && !pb_oe_n[15]; endsequence
  property p_rel; $fell(rst) |-> &{pa_oe_n, pb_oe_n, watchdog_fault_oe_n}; endproperty
  property p_ram; cpu_addr <= 16'h02FF |-> cpu_internal; endproperty
  property p_rin; !external_rom_strap && cpu_addr >= 16'hC000 |-> cpu_internal; endproperty
  property p_rout; external_rom_strap && cpu_addr >= 16'hC000 |-> !cpu_internal; endproperty
  property p_mid; cpu_addr inside {[16'h0300:16'hBFFF]} |-> !cpu_internal; endproperty
  property p_ale; s_ale |-> pa_out == cpu_addr && pa_oe_n == 16'h0000; endproperty
  property p_rd; cpu_req && !pb_oe_n[15] && $fell(pb_out[15]) |-> !cpu_internal; endproperty
  property p_str; s_rd ##0 !ext_ready |=> !pb_out[15] && !cpu_ack; endproperty
  a_rel: assert property (p_rel) else $error("pins driven after reset");
  a_ram: assert property (p_ram) else $error("ram not on-chip");
  a_rin: assert property (p_rin) else $error("rom not on-chip");
  a_rout: assert property (p_rout) else $error("rom not external");
  a_mid: assert property (p_mid) else $error("middle range on-chip");
  a_ale: assert property (p_ale) else $error("address missing at latch");
  a_rd: assert property (p_rd) else $error("strobe on internal access");
  a_str: assert property (p_str) else $error("cycle not stretched");
endmodule
bind mmp_top mmp_props i_props (.*);

/* File: mmp_mem_model.sv */
// external memory on the multiplexed bus
`timescale 1ns/1ps
module mmp_mem_model (
  // clock and bench controls
  input  wire logic        clk,
  input  wire logic        en,
  input  wire logic        slow,
  // bus pins
  input  wire logic [15:0] pa_out,
  input  wire logic [15:0] pb_out,
  output logic      [15:0] pa_in,
  output logic      [15:0] pb_in,
  output logic             ext_ready
);
  logic [15:0] mem [16];
  logic [3:0]  idx;
  logic [15:0] hold;
  initial begin
    hold = 16'hA5C3;
    ext_ready = 1'h1;
    idx = 4'h0;
    foreach (mem[i]) mem[i] = 16'h5A00;
  end
  always @(posedge clk) begin
    if (en && pb_out[10]) idx <= {pa_out[15:14], pa_out[1:0]};
    if (en && !pb_out[11]) mem[idx] <= pa_out;
    if (en) hold <= ~pa_in;
    ext_ready <= slow ? 1'($urandom) : 1'h1;
  end
  // while en is high, a released bus shows the inverse of its last level, never a stale copy
  assign pa_in = en && !pb_out[15] ? mem[idx] : hold;
  // high byte pin sits on a chip select: 16-bit bus, so the stack may live off-chip
  assign pb_in = {hold[15:13], 1'h0, hold[11:0]};
endmodule

/* File: memory_mode_and_port_control_tb.sv */
// self-checking bench for the memory mode block
`timescale 1ns/1ps
`include "mmp_map.svh"
module memory_mode_and_port_control_tb;
  import mmp_pkg::*;
  logic        clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        cpu_req = 1'h0, cpu_write = 1'h0, cpu_fetch = 1'h0, cpu_high = 1'h0;
  logic [15:0] cpu_addr = 16'h0, cpu_wdata = 16'h0, free_running_timer = 16'h0;
  logic        external_rom_strap = 1'h0, free_running_timer_tick = 1'h0;
  logic        dedicated_ext_irq_pin = 1'h0, shared_ground_irq_pin = 1'h1, uart_irq = 1'h0;
  logic [15:0] pb_alt_out = 16'h0, cpu_rdata, pa_in, pa_out, pa_oe_n, pb_in, pb_out, pb_oe_n;
  logic        pready, pslverr, cpu_ack, cpu_internal, cpu_stall, ext_ready, ext_irq;
  logic        shared_irq, capture_valid, watchdog_fault_out, watchdog_fault_oe_n;
  logic        bus_8bit, halted, idle_mode, en = 1'h0, slow = 1'h0, ill;
  logic [15:0] capture_value, d, m, alt, a;
  logic [15:0] tab [6] = '{16'h0010, 16'h02FF, 16'h0300, 16'hBFFF, 16'hC000, 16'hFFFF};
  int          num_errors = 0, cmp_count = 0, n, last;
  int          model [int];
  logic        chk_irq = 1'h0;
  logic [2:0]  pin_q = 3'h0;

  mmp_top i_dut (.*);
  mmp_mem_model i_mem (.clk(clk), .en(en), .slow(slow), .pa_out(pa_out), .pb_out(pb_out),
    .pa_in(pa_in), .pb_in(pb_in), .ext_ready(ext_ready));

  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    {dedicated_ext_irq_pin, shared_ground_irq_pin, uart_irq} <= 3'($urandom);
    free_running_timer_tick <= 1'($urandom);
    free_running_timer <= 16'($urandom);
    // copy of the pin levels that the block samples at this edge
    pin_q <= {dedicated_ext_irq_pin, shared_ground_irq_pin, uart_irq};
  end

  // registered irq outputs are settled by the falling edge
  always @(negedge clk) begin
    if (chk_irq) begin
      check_val({ext_irq, shared_irq}, {30'h0, pin_q[2], pin_q[0] | ~pin_q[1]});
    end
  end

  task automatic stop_test();
    $display("mismatches %0d, comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic limit(input int k);
    if (k >= 200) begin
      check_val(k, 32'h0);
      stop_test();
    end
  endtask

  // one apb transfer; read data lands in q at the closing edge
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
    int k;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    for (k = 0; k < 200; k++) begin
      @(posedge clk);
      if (pready === 1'h1) break;
    end
    q = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    limit(k);
  endtask

  task automatic check_reg(input logic [11:0] ad, input logic [31:0] exp);
    apb(1'h0, ad, 32'h0);
    check_val(q, exp);
  endtask

  // request is dropped inside the acknowledge cycle, as the sequencer expects
  task automatic cpu(input logic wr, input logic [15:0] ad, input logic [15:0] wd);
    @(posedge clk);
    cpu_req <= 1'h1;
    cpu_write <= wr;
    cpu_addr <= ad;
    cpu_wdata <= wd;
    cpu_fetch <= 1'($urandom);
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      #1;
      if (cpu_ack === 1'h1) break;
    end
    cpu_req <= 1'h0;
    limit(n);
  endtask

  initial begin
    void'($urandom(32'h1520));
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    // data registers of released ports read back the pin levels
    for (int i = 0; i < 7; i++) check_reg(12'(4 * i), {16'h0, i == 0 ? pa_in : i == 2 ? pb_in : 16'h0});
    check_val({pa_oe_n, pb_oe_n}, 32'hFFFF_FFFF);
    check_val(watchdog_fault_oe_n, 32'h1);
    check_val({bus_8bit, watchdog_fault_out}, 32'h0);
    apb(1'h1, 12'h020, 32'hFFFF);
    check_reg(12'h020, 32'h0);
    for (int p = 0; p < 2; p++) begin
      d = 16'($urandom);
      m = 16'($urandom);
      alt = p ? 16'($urandom) : 16'h0;
      pb_alt_out <= 16'($urandom);
      apb(1'h1, 12'(8 * p + 4), {16'h0, m});
      apb(1'h1, 12'(8 * p), {16'h0, d});
      apb(1'h1, `MMP_OFF_PB_ALT, {16'h0, alt});
      check_reg(12'(8 * p), {16'h0, d & m | (p ? pb_in : pa_in) & ~m});
      check_val(p ? pb_oe_n : pa_oe_n, {16'h0, ~m});
      check_val((p ? pb_out : pa_out) & m, {16'h0, (alt & pb_alt_out | ~alt & d) & m});
    end
    check_reg(`MMP_OFF_PB_ALT, {16'h0, alt});
    // strap and extended bit swept through all four modes, slow memory
    for (int md = 0; md < 4; md++) begin
      external_rom_strap <= md[1];
      en <= md != 0;
      slow <= 1'h1;
      apb(1'h1, `MMP_OFF_PSW, 32'(md[0] | $urandom_range(3) << 1));
      foreach (tab[k]) begin
        a = tab[k];
        ill = !md[0] && a >= 16'h0300 && a < 16'hC000;
        d = 16'($urandom);
        cpu(1'h1, a, d);
        if (!ill && a >= 16'h0300 && (md[1] || a < 16'hC000)) model[a] = d;
        cpu(1'h0, a, 16'h0);
        check_val(watchdog_fault_oe_n, {31'h0, !ill});
        if (model.exists(a)) check_val(cpu_rdata, model[a]);
        model.delete();
        apb(1'h1, `MMP_OFF_STATUS, 32'h1);
      end
    end
    slow <= 1'h0;
    last = 0;
    for (int w = 0; w < 4; w++) begin
      apb(1'h1, `MMP_OFF_PSW, 32'(2 * w + 1));
      cpu(1'h0, 16'h0300, 16'h0);
      check_val(n, 32'(3 + w));
      last = n;
    end
    // level-high sensing on the dedicated pin, ground pin used as irq
    apb(1'h1, `MMP_OFF_IRQ_CFG, 32'hA);
    @(posedge clk);
    chk_irq <= 1'h1;
    repeat (50) @(posedge clk);
    chk_irq <= 1'h0;
    @(posedge clk);
    stop_test();
  end
endmodule
